/* File: pkg/pshp_consts.svh */
// register map, field positions and reset values of the host port block
`ifndef PSHP_CONSTS_SVH
`define PSHP_CONSTS_SVH
`define PSHP_ADDR_W          4
`define PSHP_OFF_PE_CTRL     4'h0
`define PSHP_OFF_PE_PINS     4'h1
`define PSHP_OFF_PE_LATCH    4'h2
`define PSHP_OFF_PD_PINS     4'h3
`define PSHP_OFF_PD_LATCH    4'h4
`define PSHP_OFF_PD_DIR      4'h5
`define PSHP_OFF_PIR_ONE     4'h6
`define PSHP_OFF_PIE_ONE     4'h7
`define PSHP_OFF_IPR_ONE     4'h8
`define PSHP_OFF_CONV_ONE    4'h9
`define PSHP_BIT_IBF         7
`define PSHP_BIT_OBF         6
`define PSHP_BIT_INPUT_OVERFLOW_FLAG        5
`define PSHP_BIT_MODE        4
`define PSHP_BIT_HOST_IRQ    7
`define PSHP_RST_PE_CTRL     8'h07
`define PSHP_RST_PD_DIR      8'hFF
`define PSHP_RST_ZERO        8'h00
`define PSHP_PCFG_DIGITAL    3'h7
`endif

/* File: pkg/pshp_pkg.sv */
// types shared by the host port block
package pshp_pkg;
  // port-E control register layout
  typedef struct packed {
    logic       input_full_flag;
    logic       output_full_flag;
    logic       input_overflow_flag;
    logic       host_port_select;
    logic       unused_zero;
    logic [2:0] pe_direction;
  } pshp_ctrl_t;
  // port-E pins as host control strobes, all active low
  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
  } pshp_strobe_t;
  // software register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pshp_bus_t;
endpackage

/* File: rtl/pshp_top.sv */
// parallel slave host port with port D / port E pin control
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`include "pshp_consts.svh"
module pshp_top (
  input  wire logic              i_sys_clk,  // 125 MHz system clock
  input  wire logic              i_rst_n,    // sync reset, active low
  input  wire pshp_pkg::pshp_bus_t i_bus,    // register bus request
  output logic [7:0]             o_rdata,    // read data, cycle after
  output logic                   o_irq,      // level interrupt
  output logic                   o_irq_prio, // priority of the interrupt
  input  wire logic [7:0]        i_pd_in,    // port D pin levels
  output logic [7:0]             o_pd_out,   // port D drive value
  output logic [7:0]             o_pd_oe,    // port D drive enable
  input  wire logic [2:0]        i_pe_in,    // port E pin levels
  output logic [2:0]             o_pe_out,   // port E drive value
  output logic [2:0]             o_pe_oe     // port E drive enable
);
  import pshp_pkg::*;

  logic [10:0]  s1_q;
  logic [10:0]  s2_q;
  logic [10:0]  s3_q;
  logic [10:0]  filt_q;
  logic [10:0]  filt_d;
  pshp_ctrl_t   ctrl_q;
  logic [7:0]   pe_latch_q;
  logic [7:0]   pd_latch_q;
  logic [7:0]   pd_dir_q;
  logic [7:0]   pd_in_q;
  logic         irq_flag_q;
  logic         irq_en_q;
  logic         irq_prio_q;
  logic [7:0]   conv_q;
  logic         wr_act_q;
  logic         rd_act_q;
  logic         pe_digital;
  pshp_strobe_t strobe;
  logic [7:0]   pd_pins;
  logic [2:0]   pe_pins;
  logic         wr_act;
  logic         rd_act;
  logic         host_wr;
  logic         host_rd;
  logic         host_done;
  logic         cpu_wr_ctrl;
  logic         cpu_rd_pd;
  logic         cpu_wr_pd;
  logic [7:0]   rd_mux;

  // strobe decode used for both host strobes
  function automatic logic strobe_on(input logic sel, input logic cs_n,
                                     input logic st_n);
    strobe_on = sel & ~cs_n & ~st_n;
  endfunction

  // three-stage synchroniser for all pins; only s2 and s3 are compared;
  // stages reset to the idle strobe level so the filter sees no false
  // low right after reset
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      s1_q <= 11'h7FF;
      s2_q <= 11'h7FF;
      s3_q <= 11'h7FF;
    end else begin
      s1_q <= {i_pe_in, i_pd_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a bit changes only once the second and third stage agree
  assign filt_d = (s2_q & s3_q) | (filt_q & (s2_q | s3_q));

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      filt_q <= 11'h7FF; // idle strobes read high after reset
    end else begin
      filt_q <= filt_d;
    end
  end

  // analog-configured pins read as zero, so strobes are held inactive
  assign pe_digital = (conv_q[2:0] == `PSHP_PCFG_DIGITAL);
  assign pd_pins    = filt_q[7:0];
  assign pe_pins    = pe_digital ? filt_q[10:8] : 3'h0;
  assign strobe     = pe_digital ? pshp_strobe_t'(filt_q[10:8]) : 3'h7;

  // host accesses only count in host port mode with chip selected
  assign wr_act = strobe_on(ctrl_q.host_port_select, strobe.cs_n,
                            strobe.wr_n);
  assign rd_act = strobe_on(ctrl_q.host_port_select, strobe.cs_n,
                            strobe.rd_n);
  assign host_wr   = wr_act & ~wr_act_q;
  assign host_rd   = rd_act & ~rd_act_q;
  // the access completes when its strobe pair is released
  assign host_done = (wr_act_q & ~wr_act) | (rd_act_q & ~rd_act);

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
    end else begin
      wr_act_q <= wr_act;
      rd_act_q <= rd_act;
    end
  end

  // cpu side decode
  assign cpu_wr_ctrl = i_bus.wr & (i_bus.addr == `PSHP_OFF_PE_CTRL);
  assign cpu_rd_pd   = i_bus.rd & (i_bus.addr == `PSHP_OFF_PD_PINS);
  assign cpu_wr_pd   = i_bus.wr & ((i_bus.addr == `PSHP_OFF_PD_PINS) |
                                   (i_bus.addr == `PSHP_OFF_PD_LATCH));

  // port-E control: mode and directions by software
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ctrl_q.host_port_select <= 1'b0;
      ctrl_q.pe_direction     <= 3'h7;
    end else if (cpu_wr_ctrl) begin
      ctrl_q.host_port_select <= i_bus.wdata[`PSHP_BIT_MODE];
      ctrl_q.pe_direction     <= i_bus.wdata[2:0];
    end
  end

  // bit 3 is not implemented
  always_ff @(posedge i_sys_clk) begin
    ctrl_q.unused_zero <= 1'b0;
  end

  // input full: host write sets, cpu read of port D clears, set wins
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ctrl_q.input_full_flag <= 1'b0;
    end else if (host_wr) begin
      ctrl_q.input_full_flag <= 1'b1;
    end else if (cpu_rd_pd && ctrl_q.host_port_select) begin
      ctrl_q.input_full_flag <= 1'b0;
    end
  end

  // output full: cpu write sets, host read clears, set wins
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ctrl_q.output_full_flag <= 1'b0;
    end else if (cpu_wr_pd && ctrl_q.host_port_select) begin
      ctrl_q.output_full_flag <= 1'b1;
    end else if (host_rd) begin
      ctrl_q.output_full_flag <= 1'b0;
    end
  end

  // overflow sticks until software writes zero to it; set wins
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ctrl_q.input_overflow_flag <= 1'b0;
    end else if (host_wr && ctrl_q.input_full_flag) begin
      ctrl_q.input_overflow_flag <= 1'b1;
    end else if (cpu_wr_ctrl && !i_bus.wdata[`PSHP_BIT_INPUT_OVERFLOW_FLAG]) begin
      ctrl_q.input_overflow_flag <= 1'b0;
    end
  end

  // input latch captures all eight host data bits at once
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      pd_in_q <= `PSHP_RST_ZERO;
    end else if (host_wr) begin
      pd_in_q <= pd_pins;
    end
  end

  // output latches and directions
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      pd_latch_q <= `PSHP_RST_ZERO;
      pe_latch_q <= `PSHP_RST_ZERO;
      pd_dir_q   <= `PSHP_RST_PD_DIR;
      conv_q     <= `PSHP_RST_ZERO;
    end else if (i_bus.wr) begin
      if (cpu_wr_pd) begin
        pd_latch_q <= i_bus.wdata;
      end
      if ((i_bus.addr == `PSHP_OFF_PE_PINS) ||
          (i_bus.addr == `PSHP_OFF_PE_LATCH)) begin
        pe_latch_q <= {5'h00, i_bus.wdata[2:0]};
      end
      if (i_bus.addr == `PSHP_OFF_PD_DIR) begin
        pd_dir_q <= i_bus.wdata;
      end
      if (i_bus.addr == `PSHP_OFF_CONV_ONE) begin
        conv_q <= i_bus.wdata;
      end
    end
  end

  // interrupt flag is write-one-to-clear; a completing host access wins the cycle
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      irq_flag_q <= 1'b0;
    end else if (host_done) begin
      irq_flag_q <= 1'b1;
    end else if (i_bus.wr && (i_bus.addr == `PSHP_OFF_PIR_ONE) &&
                 i_bus.wdata[`PSHP_BIT_HOST_IRQ]) begin
      irq_flag_q <= 1'b0;
    end
  end

  // interrupt enable and priority
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      irq_en_q   <= 1'b0;
      irq_prio_q <= 1'b0;
    end else if (i_bus.wr) begin
      if (i_bus.addr == `PSHP_OFF_PIE_ONE) begin
        irq_en_q <= i_bus.wdata[`PSHP_BIT_HOST_IRQ];
      end
      if (i_bus.addr == `PSHP_OFF_IPR_ONE) begin
        irq_prio_q <= i_bus.wdata[`PSHP_BIT_HOST_IRQ];
      end
    end
  end

  // registered interrupt outputs
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_irq      <= 1'b0;
      o_irq_prio <= 1'b0;
    end else begin
      o_irq      <= irq_flag_q & irq_en_q;
      o_irq_prio <= irq_prio_q;
    end
  end

  // read mux; port D pins return the host byte in host port mode
  always_comb begin
    rd_mux = `PSHP_RST_ZERO;
    unique case (i_bus.addr)
      `PSHP_OFF_PE_CTRL:  rd_mux = ctrl_q;
      `PSHP_OFF_PE_PINS:  rd_mux = {5'h00, pe_pins};
      `PSHP_OFF_PE_LATCH: rd_mux = pe_latch_q;
      `PSHP_OFF_PD_PINS:  rd_mux = ctrl_q.host_port_select ? pd_in_q
                                                           : pd_pins;
      `PSHP_OFF_PD_LATCH: rd_mux = pd_latch_q;
      `PSHP_OFF_PD_DIR:   rd_mux = pd_dir_q;
      `PSHP_OFF_PIR_ONE:  rd_mux = {irq_flag_q, 7'h00};
      `PSHP_OFF_PIE_ONE:  rd_mux = {irq_en_q, 7'h00};
      `PSHP_OFF_IPR_ONE:  rd_mux = {irq_prio_q, 7'h00};
      `PSHP_OFF_CONV_ONE: rd_mux = conv_q;
      default:            rd_mux = `PSHP_RST_ZERO; // unmapped reads zero
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_rdata <= `PSHP_RST_ZERO;
    end else if (i_bus.rd) begin
      o_rdata <= rd_mux;
    end else begin
      o_rdata <= `PSHP_RST_ZERO;
    end
  end

  // pin drivers; in host port mode port D drives only while host reads,
  // port E never drives, whatever the direction bits hold
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_pd_out <= `PSHP_RST_ZERO;
      o_pd_oe  <= `PSHP_RST_ZERO;
      o_pe_out <= 3'h0;
      o_pe_oe  <= 3'h0;
    end else begin
      o_pd_out <= pd_latch_q;
      o_pe_out <= pe_latch_q[2:0];
      if (ctrl_q.host_port_select) begin
        o_pd_oe <= {8{rd_act}};
        o_pe_oe <= 3'h0;
      end else begin
        o_pd_oe <= ~pd_dir_q;
        o_pe_oe <= ~ctrl_q.pe_direction;
      end
    end
  end

endmodule // pshp_top

/* File: verification/pshp_host_model.sv */
// external microprocessor model driving the host port pins
`timescale 1ns/1ns
module pshp_host_model (
  input  wire logic       i_sys_clk, // bench clock, pacing only
  input  wire logic [7:0] i_d,       // port D wire level
  output logic [2:0]      o_ctl,     // cs_n, wr_n, rd_n
  output logic [7:0]      o_d        // data driven by the master
);
  // idle: deselected, strobes high
  initial begin
    o_ctl = 3'h7;
    o_d = 8'h00;
  end
  // one write; sel low keeps chip select high to test gating
  task automatic host_write(input logic [7:0] d, input logic sel);
    @(posedge i_sys_clk);
    o_d <= d;
    o_ctl <= {~sel, 2'b01};
    repeat (8) @(posedge i_sys_clk);
    o_ctl <= 3'h7;
    @(posedge i_sys_clk);
    o_d <= ~d; // released bus shows no stale value
    repeat (7) @(posedge i_sys_clk);
  endtask
  // one read; data sampled while strobes still low
  task automatic host_read(output logic [7:0] d);
    @(posedge i_sys_clk);
    o_ctl <= 3'b010;
    repeat (8) @(posedge i_sys_clk);
    d = i_d;
    o_ctl <= 3'h7;
    repeat (8) @(posedge i_sys_clk);
  endtask
endmodule // pshp_host_model

/* File: verification/pshp_top_assertions.sv */
// concurrent checks on the host port block pins
`timescale 1ns/1ns
module pshp_top_assertions (
  input wire logic                i_sys_clk,  // system clock
  input wire logic                i_rst_n,    // sync reset
  input wire pshp_pkg::pshp_bus_t i_bus,      // register bus
  input wire logic [7:0]          o_rdata,    // read data
  input wire logic                o_irq,      // interrupt
  input wire logic                o_irq_prio, // interrupt priority
  input wire logic [7:0]          o_pd_oe,    // port D enable
  input wire logic [2:0]          i_pe_in     // host strobes
);
  import pshp_pkg::*;
  logic mode_q;
  logic dig_q;
  logic en_q;
  logic hostm;
  // shadow of mode, pin config and irq enable seen on the bus
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      mode_q <= 1'b0;
      dig_q  <= 1'b0;
      en_q   <= 1'b0;
    end else if (i_bus.wr) begin
      if (i_bus.addr == 4'h0) mode_q <= i_bus.wdata[4];
      if (i_bus.addr == 4'h9) dig_q <= (i_bus.wdata[2:0] == 3'h7);
      if (i_bus.addr == 4'h7) en_q <= i_bus.wdata[7];
    end
  end
  assign hostm = mode_q & dig_q;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  a_rdata_idle: assert property (
    !$past(i_bus.rd) |-> o_rdata == 8'h00) else $error("rdata not idle");
  a_unmapped_zero: assert property (
    $past(i_bus.rd && i_bus.addr > 4'h9) |-> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ctrl_bit3: assert property (
    $past(i_bus.rd && i_bus.addr == 4'h0) |-> !o_rdata[3])
    else $error("control bit 3 set");
  a_oe_after_rst: assert property (
    $rose(i_rst_n) |-> o_pd_oe == 8'h00) else $error("port D driven");
  a_irq_after_rst: assert property (
    $rose(i_rst_n) |-> !o_irq && !o_irq_prio) else $error("irq at reset");
  a_irq_masked: assert property (
    !en_q && !$past(en_q) |-> !o_irq) else $error("masked irq seen");
  a_read_drive: assert property (
    (hostm && i_pe_in == 3'b010) [*7] |-> o_pd_oe == 8'hFF)
    else $error("host read not driven");
  a_desel_quiet: assert property (
    (hostm && i_pe_in[2]) [*7] |-> o_pd_oe == 8'h00)
    else $error("driven while deselected");
endmodule // pshp_top_assertions
bind pshp_top pshp_top_assertions u_chk (.i_sys_clk(i_sys_clk),
  .i_rst_n(i_rst_n), .i_bus(i_bus), .o_rdata(o_rdata), .o_irq(o_irq),
  .o_irq_prio(o_irq_prio), .o_pd_oe(o_pd_oe), .i_pe_in(i_pe_in));

/* File: verification/tb.sv */
// self-checking bench for the host port block
`timescale 1ns/1ns
module tb;
  import pshp_pkg::*;
  logic i_sys_clk, i_rst_n, irq, prio;
  pshp_bus_t bus;
  logic [7:0] rdata, pd_out, pd_oe, hd, got;
  logic [2:0] pe_out, pe_oe, ctl;
  int err_total = 0;
  int n_checks = 0;
  pshp_top u_pshp_top (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_bus(bus), .o_rdata(rdata), .o_irq(irq), .o_irq_prio(prio),
    .i_pd_in((pd_oe & pd_out) | (~pd_oe & hd)), .o_pd_out(pd_out),
    .o_pd_oe(pd_oe), .i_pe_in((pe_oe & pe_out) | (~pe_oe & ctl)),
    .o_pe_out(pe_out), .o_pe_oe(pe_oe));
  pshp_host_model u_host (.i_sys_clk(i_sys_clk),
    .i_d((pd_oe & pd_out) | (~pd_oe & hd)), .o_ctl(ctl), .o_d(hd));
  // free-running 125 MHz clock
  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(logic [3:0] a, logic [7:0] d);
    @(posedge i_sys_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_sys_clk);
    bus.wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd_reg(logic [3:0] a, logic [7:0] e, string nm);
    @(posedge i_sys_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_sys_clk);
    bus.rd <= 1'b0;
    #1 chk(nm, e, rdata);
  endtask
  // irq output is registered behind flag and enable: allow two edges
  task automatic chk_irq(logic e, string nm);
    repeat (2) @(posedge i_sys_clk);
    #1 chk(nm, {7'h00, e}, {7'h00, irq});
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #100000 err_total++;
    complete_run;
  end
  initial begin
    bus = '0;
    i_rst_n = 1'b0;
    repeat (12) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    rd_reg(4'h0, 8'h07, "ctrl reset");
    rd_reg(4'h5, 8'hFF, "pd dir reset");
    rd_reg(4'h6, 8'h00, "flags reset");
    wr_reg(4'hF, 8'hFF);
    rd_reg(4'hF, 8'h00, "unmapped");
    wr_reg(4'h0, 8'hFF);
    rd_reg(4'h0, 8'h17, "ctrl host");
    wr_reg(4'h9, 8'h07);
    wr_reg(4'h7, 8'h80);
    u_host.host_write(8'hA5, 1'b1);
    rd_reg(4'h0, 8'h97, "input full");
    chk_irq(1'b1, "irq raised");
    wr_reg(4'h6, 8'h80);
    chk_irq(1'b0, "irq cleared");
    u_host.host_write(8'h3C, 1'b1);
    rd_reg(4'h0, 8'hB7, "overflow");
    wr_reg(4'h7, 8'h00);
    chk_irq(1'b0, "irq masked");
    rd_reg(4'h3, 8'h3C, "host byte");
    rd_reg(4'h0, 8'h37, "full cleared");
    wr_reg(4'h0, 8'h17);
    rd_reg(4'h0, 8'h17, "overflow cleared");
    wr_reg(4'h4, 8'h5A);
    rd_reg(4'h0, 8'h57, "output full");
    u_host.host_read(got);
    chk("host read", 8'h5A, got);
    rd_reg(4'h0, 8'h17, "output read");
    u_host.host_write(8'h11, 1'b0);
    rd_reg(4'h0, 8'h17, "deselected");
    wr_reg(4'h0, 8'h07);
    u_host.host_write(8'h22, 1'b1);
    rd_reg(4'h0, 8'h07, "gpio mode");
    chk("pd out", 8'h5A, pd_out);
    chk("pd oe", 8'h00, pd_oe);
    wr_reg(4'h0, 8'h05);
    rd_reg(4'h0, 8'h05, "dir write");
    chk("pe oe", 8'h02, {5'h00, pe_oe});
    wr_reg(4'h8, 8'h80);
    rd_reg(4'h8, 8'h80, "prio reg");
    chk("irq prio", 8'h01, {7'h00, prio});
    complete_run;
  end
endmodule // tb
